// ---- rtl/asp_control_port.v ----
// Serial control port, conversion sequencer and port outputs of the converter.
`timescale 1ns/100ps
`default_nettype none
`include "asp_map.vh"
module asp_control_port #(
	parameter RES_W     = `ASP_RES_W,
	parameter CAL_STEPS = `ASP_CAL_STEPS,
	parameter INT_DIV   = 4
) (
	input  wire             core_clk_i,
	input  wire             reset_i,
	input  wire             reset_low_input_n_i,
	input  wire             shutdown_n_i,
	input  wire             chip_select_n_i,
	input  wire             serial_clk_i,
	input  wire             control_in_i,
	input  wire [RES_W-1:0] sample_code_i,
	output reg              serial_result_out_o,
	output wire             serial_result_oe_n_o,
	output reg              conversion_strobe_o,
	output wire             conversion_strobe_oe_n_o,
	output reg              port_out_0_o,
	output reg              port_out_1_o,
	output reg              port_out_2_o,
	output reg              polarity_sel_o,
	output reg              busy_o
);
	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	reg  [1:0] rst_sync_reg;
	reg  [1:0] shutdown_n_sync_reg;
	reg  [1:0] cs_sync_reg;
	reg  [1:0] sck_sync_reg;
	reg  [1:0] din_sync_reg;
	reg        sck_last_reg;
	reg        cs_last_reg;
	wire       rst_low = ~rst_sync_reg[1];
	wire       shutdown_n    = ~shutdown_n_sync_reg[1];
	wire       cs_n    = cs_sync_reg[1];
	wire       sck_rise = sck_sync_reg[1] & ~sck_last_reg;
	wire       sck_fall = ~sck_sync_reg[1] & sck_last_reg;
	wire       cs_fall  = ~cs_n & cs_last_reg;

	always @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			rst_sync_reg  <= 2'h0;
			shutdown_n_sync_reg <= 2'h3;
			cs_sync_reg   <= 2'h3;
			sck_sync_reg  <= 2'h0;
			din_sync_reg  <= 2'h0;
			sck_last_reg  <= 1'b0;
			cs_last_reg   <= 1'b1;
		end else begin
			rst_sync_reg  <= {rst_sync_reg[0], reset_low_input_n_i};
			shutdown_n_sync_reg <= {shutdown_n_sync_reg[0], shutdown_n_i};
			cs_sync_reg   <= {cs_sync_reg[0], chip_select_n_i};
			sck_sync_reg  <= {sck_sync_reg[0], serial_clk_i};
			din_sync_reg  <= {din_sync_reg[0], control_in_i};
			sck_last_reg  <= sck_sync_reg[1];
			cs_last_reg   <= cs_n;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	localparam ST_IDLE = 3'h0;
	localparam ST_RECV = 3'h1;
	localparam ST_ACQ  = 3'h2;
	localparam ST_CONV = 3'h3;
	localparam ST_CAL  = 3'h4;
	localparam ST_PDN  = 3'h5;

	reg [2:0]       state_reg;
	reg             armed_reg;
	reg [6:0]       shift_reg;
	reg [2:0]       bitcnt_reg;
	reg             clk_int_reg;
	reg [1:0]       mode_reg;
	reg [5:0]       acq_cnt_reg;
	reg [4:0]       step_reg;
	reg [RES_W-1:0] result_reg;
	reg [RES_W-1:0] code_reg;
	reg [7:0]       cal_cnt_reg;
	reg             strobe_pend_reg;
	reg [7:0]       div_reg;
	reg             out_en_reg;

	wire [7:0] byte_in  = {shift_reg, din_sync_reg[1]};
	wire [1:0] mode_in  = {byte_in[`ASP_BIT_M1], byte_in[`ASP_BIT_M0]};
	wire       int_tick = (div_reg == INT_DIV[7:0] - 8'h01);
	// Conversion steps come from falling serial edges or the internal divider.
	wire       step_ev  = clk_int_reg ? int_tick : sck_fall; // [RL6] [RL21]
	wire       new_start = sck_rise & armed_reg & ~cs_n & din_sync_reg[1]; // [RL16] [RL17]
	wire       byte_done = (state_reg == ST_RECV) & sck_rise & ~cs_n & (bitcnt_reg == 3'h6);
	wire [RES_W-1:0] conv_code = polarity_sel_o ? sample_code_i
		: (sample_code_i ^ {1'b1, {(RES_W-1){1'b0}}}); // [RL2] [RL14]

	assign serial_result_oe_n_o     = cs_n; // [RL7]
	assign conversion_strobe_oe_n_o = cs_n & ~clk_int_reg; // [RL8]

	always @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg           <= ST_IDLE;
			armed_reg           <= 1'b0;
			shift_reg           <= 7'h00;
			bitcnt_reg          <= 3'h0;
			clk_int_reg         <= 1'b0;
			mode_reg            <= 2'h0;
			acq_cnt_reg         <= 6'h00;
			step_reg            <= 5'h00;
			result_reg          <= {RES_W{1'b0}};
			code_reg            <= {RES_W{1'b0}};
			cal_cnt_reg         <= 8'h00;
			strobe_pend_reg     <= 1'b0;
			div_reg             <= 8'h00;
			out_en_reg          <= 1'b0;
			serial_result_out_o <= 1'b0;
			conversion_strobe_o <= 1'b0;
			port_out_0_o        <= 1'b0;
			port_out_1_o        <= 1'b0;
			port_out_2_o        <= 1'b0;
			polarity_sel_o      <= 1'b0;
			busy_o              <= 1'b0;
		end else if (rst_low) begin
			state_reg           <= ST_IDLE; // [RL5]
			armed_reg           <= 1'b0;
			bitcnt_reg          <= 3'h0;
			clk_int_reg         <= 1'b0;
			mode_reg            <= 2'h0;
			strobe_pend_reg     <= 1'b0;
			out_en_reg          <= 1'b0;
			serial_result_out_o <= 1'b0;
			conversion_strobe_o <= 1'b0;
			port_out_0_o        <= 1'b0; // [RL19]
			port_out_1_o        <= 1'b0;
			port_out_2_o        <= 1'b0;
			polarity_sel_o      <= 1'b0;
			busy_o              <= 1'b0;
		end else begin
			div_reg <= int_tick ? 8'h00 : div_reg + 8'h01;
			if (cs_fall)
				armed_reg <= 1'b1; // [RL24]
			if (cs_n)
				bitcnt_reg <= 3'h0; // [RL17]
			// Serial output changes only on falling serial edges.
			if (sck_fall & ~cs_n) begin
				if (strobe_pend_reg | (state_reg == ST_CONV & step_reg != 5'h00)) begin
					serial_result_out_o <= result_reg[RES_W-1]; // [RL2] [RL3] [RL11]
					result_reg <= {result_reg[RES_W-2:0], 1'b0};
				end else begin
					serial_result_out_o <= 1'b0;
				end
			end
			if (~clk_int_reg & sck_fall)
				conversion_strobe_o <= strobe_pend_reg; // [RL9]
			if (new_start) begin
				// A fresh start bit aborts whatever is running.
				state_reg  <= ST_RECV; // [RL24]
				armed_reg  <= 1'b0;
				bitcnt_reg <= 3'h0;
				shift_reg  <= 7'h01;
				busy_o     <= 1'b0;
			end else begin
				case (state_reg)
				ST_IDLE: begin
				end
				ST_RECV: begin
					if (sck_rise & ~cs_n) begin
						shift_reg  <= byte_in[6:0]; // [RL4]
						bitcnt_reg <= bitcnt_reg + 3'h1;
					end
					if (byte_done) begin
						port_out_0_o   <= byte_in[0]; // [RL18] [RL25]
						port_out_1_o   <= byte_in[1];
						port_out_2_o   <= byte_in[2];
						polarity_sel_o <= byte_in[`ASP_BIT_POL]; // [RL14]
						clk_int_reg    <= byte_in[`ASP_BIT_CLKSRC]; // [RL21]
						mode_reg       <= mode_in; // [RL22]
						acq_cnt_reg    <= 6'h00;
						cal_cnt_reg    <= 8'h00;
						busy_o         <= (mode_in != `ASP_MODE_PDN);
						if (mode_in == `ASP_MODE_CAL)
							state_reg <= ST_CAL; // [RL12]
						else if (mode_in == `ASP_MODE_PDN)
							state_reg <= ST_PDN;
						else
							state_reg <= ST_ACQ;
					end
				end
				ST_ACQ: begin
					// Acquisition is counted in falling serial edges after the eighth control bit.
					if (sck_fall & ~shutdown_n) begin // [RL15]
						acq_cnt_reg <= acq_cnt_reg + 6'h01;
						if (acq_cnt_reg == ((mode_reg == `ASP_MODE_LONG) ?
							`ASP_ACQ_LONG : `ASP_ACQ_SHORT) - 6'h01) begin // [RL23]
							code_reg   <= conv_code; // [RL1]
							result_reg <= conv_code;
							step_reg   <= 5'h00;
							state_reg  <= ST_CONV;
							strobe_pend_reg <= ~clk_int_reg;
							if (clk_int_reg)
								conversion_strobe_o <= 1'b0; // [RL10]
						end
					end
				end
				ST_CONV: begin
					if (sck_fall)
						strobe_pend_reg <= 1'b0;
					// One successive-approximation decision per step.
					if (step_ev & ~shutdown_n) begin // [RL6] [RL15]
						step_reg <= step_reg + 5'h01;
						if (step_reg == RES_W[4:0] - 5'h01) begin
							state_reg <= ST_IDLE;
							armed_reg <= 1'b1; // [RL16]
							busy_o    <= 1'b0;
							if (clk_int_reg) begin
								result_reg <= code_reg; // [RL11]
								conversion_strobe_o <= 1'b1; // [RL10]
							end
						end
					end
				end
				ST_CAL: begin
					if (step_ev & ~shutdown_n) begin // [RL12]
						cal_cnt_reg <= cal_cnt_reg + 8'h01;
						if (cal_cnt_reg == CAL_STEPS[7:0] - 8'h01) begin
							state_reg <= ST_IDLE;
							armed_reg <= 1'b1; // [RL16]
							busy_o    <= 1'b0;
						end
					end
				end
				ST_PDN: begin
					// Software power-down waits for the next start bit; ports hold.
					armed_reg <= 1'b1; // [RL20]
				end
				default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ---- rtl/asp_map.vh ----
// Constants and field positions of the serial control port of the converter.
// What this block does
// [RL1] Produce 14-bit successive-approximation conversion results.
// [RL2] Shift result MSB first, binary or two's complement.
// [RL3] Change serial output only on serial clock falls.
// [RL4] Sample control input on rising serial clock edges.
// [RL5] Reset low restores every power-on default.
// [RL6] External clock mode: one step per serial clock.
// [RL7] Serial output floats while chip select high.
// [RL8] External mode: strobe floats while chip select high.
// [RL9] External mode: strobe pulses one clock at start.
// [RL10] Internal mode: strobe low during, high after.
// [RL11] Read during conversion external, after internal; code shifts result bits only during conversion in both modes.
// [RL12] Mode pair 01 starts calibration on chosen clock.
// [RL13] Host calibrates with its conversion clock source.
// [RL14] Control bit 6 selects unipolar or bipolar.
// [RL15] Shutdown low suspends conversion activity.
// [RL16] Zeros ignored; first one starts control byte.
// [RL17] Bytes accepted only while chip select low.
// [RL18] Control bits 0..2 drive port outputs 0..2.
// [RL19] Port outputs clear at any reset.
// [RL20] Port outputs hold and drive during shutdown.
// [RL21] Bit 5 one selects internal conversion clock.
// [RL22] Mode pair: 24-clock, calibrate, power-down, 32-clock.
// [RL23] Strobe after edge 7 or 15; MSB next edge.
// [RL24] Chip select toggle re-arms; new start aborts.
// [RL25] All port outputs update together after bit eight.
`ifndef ASP_MAP_VH
`define ASP_MAP_VH
`define ASP_RES_W        14
`define ASP_BIT_POL      6
`define ASP_BIT_CLKSRC   5
`define ASP_BIT_M1       4
`define ASP_BIT_M0       3
`define ASP_MODE_SHORT   2'h0
`define ASP_MODE_CAL     2'h1
`define ASP_MODE_PDN     2'h2
`define ASP_MODE_LONG    2'h3
`define ASP_ACQ_SHORT    6'h07
`define ASP_ACQ_LONG     6'h0f
`define ASP_CAL_STEPS    8'h40
`endif

// ---- verif/asp_control_port_monitor.sv ----
// Port assertions of the converter control port.
`timescale 1ns/100ps
`default_nettype none
module asp_control_port_monitor (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic reset_low_input_n_i,
	input wire logic shutdown_n_i,
	input wire logic chip_select_n_i,
	input wire logic serial_clk_i,
	input wire logic serial_result_out_o,
	input wire logic serial_result_oe_n_o,
	input wire logic conversion_strobe_o,
	input wire logic conversion_strobe_oe_n_o,
	input wire logic port_out_0_o,
	input wire logic port_out_1_o,
	input wire logic port_out_2_o,
	input wire logic polarity_sel_o,
	input wire logic busy_o
);
	logic [3:0] cfg;
	assign cfg = {polarity_sel_o, port_out_2_o, port_out_1_o, port_out_0_o};
	default clocking mon_cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	sequence strobe_high_s; conversion_strobe_o[*6]; endsequence
	sequence strobe_end_s; ##[0:3] !conversion_strobe_o; endsequence
	res_float_a: assert property (chip_select_n_i[*4] |-> serial_result_oe_n_o)
		else $error("result pin driven while deselected");
	res_drive_a: assert property (!chip_select_n_i[*4] |-> !serial_result_oe_n_o)
		else $error("result pin floats while selected");
	strobe_drive_a: assert property (!chip_select_n_i[*4] |-> !conversion_strobe_oe_n_o)
		else $error("strobe floats while selected");
	pin_reset_a: assert property (!reset_low_input_n_i[*4] |-> cfg == 4'h0 && !busy_o)
		else $error("pin reset left state set");
	res_edge_a: assert property ($changed(serial_result_out_o) && !serial_result_oe_n_o &&
		$past(!serial_result_oe_n_o) && $past(reset_low_input_n_i, 3) |-> !serial_clk_i)
		else $error("result bit changed with serial clock high");
	port_hold_a: assert property ((chip_select_n_i && reset_low_input_n_i)[*8] |=> $stable(cfg))
		else $error("ports changed while deselected");
	strobe_width_a: assert property ($rose(conversion_strobe_o) && busy_o |->
		strobe_high_s ##1 strobe_end_s)
		else $error("strobe width is not one serial period");
	shutdown_n_freeze_a: assert property ((!shutdown_n_i && reset_low_input_n_i)[*4] ##0 busy_o |=> busy_o)
		else $error("work ended during shutdown");
endmodule
bind asp_control_port asp_control_port_monitor i_asp_control_port_monitor (.core_clk_i, .reset_i,
	.reset_low_input_n_i, .shutdown_n_i, .chip_select_n_i, .serial_clk_i, .serial_result_out_o,
	.serial_result_oe_n_o, .conversion_strobe_o, .conversion_strobe_oe_n_o, .port_out_0_o,
	.port_out_1_o, .port_out_2_o, .polarity_sel_o, .busy_o);
`default_nettype wire

// ---- verif/asp_control_port_tb.sv ----
// Self-checking bench of the converter control port.
`timescale 1ns/100ps
`default_nettype none
module asp_control_port_tb;
	logic        core_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        reset_low_input_n_i = 1'b1;
	logic        shutdown_n_i = 1'b1;
	logic [13:0] sample_code_i = 14'h2a5c;
	logic        chip_select_n_i, serial_clk_i, control_in_i, serial_result_out_o;
	logic        serial_result_oe_n_o, conversion_strobe_o, conversion_strobe_oe_n_o;
	logic        port_out_0_o, port_out_1_o, port_out_2_o, polarity_sel_o, busy_o;
	logic [31:0] rx;
	logic [7:0]  cb [5] = '{8'hc5, 8'h9a, 8'heb, 8'hd6, 8'he4};
	int          len [5] = '{33, 41, 10, 10, 17};
	int          error_cnt = 0;
	int          check_count = 0;
	always #5 core_clk_i = ~core_clk_i;
	asp_control_port i_asp_control_port (.core_clk_i, .reset_i, .reset_low_input_n_i,
		.shutdown_n_i, .chip_select_n_i, .serial_clk_i, .control_in_i, .sample_code_i,
		.serial_result_out_o, .serial_result_oe_n_o, .conversion_strobe_o,
		.conversion_strobe_oe_n_o, .port_out_0_o, .port_out_1_o, .port_out_2_o,
		.polarity_sel_o, .busy_o);
	asp_host_model i_asp_host_model (.core_clk_i, .res_i(serial_result_out_o),
		.res_oe_n_i(serial_result_oe_n_o), .cs_n_o(chip_select_n_i), .sclk_o(serial_clk_i),
		.ctl_o(control_in_i));
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic wait_idle;
		int n;
		for (n = 0; n < 3000 && busy_o !== 1'b0; n++) tick(1);
		if (n == 3000) begin
			check(busy_o, 1'b0);
			summarize;
		end
	endtask
	initial begin
		tick(12);
		reset_i = 1'b0;
		tick(4);
		for (int r = 0; r < 5; r++) begin
			i_asp_host_model.xfer(cb[r], len[r], rx);
			check({port_out_2_o, port_out_1_o, port_out_0_o}, cb[r][2:0]);
			check(polarity_sel_o, cb[r][6]);
			if (r == 0) check(rx[15:2], sample_code_i);
			if (r == 1) check(rx[15:2], sample_code_i ^ 14'h2000);
			if (r > 1) check(busy_o, r != 3);
			wait_idle;
			if (r == 4) check(conversion_strobe_o, 1'b1);
			sample_code_i = sample_code_i + 14'h0413;
		end
		i_asp_host_model.xfer(8'he7, 17, rx);
		shutdown_n_i = 1'b0;
		check(conversion_strobe_o, 1'b0);
		tick(500);
		check(busy_o, 1'b1);
		check({port_out_2_o, port_out_1_o, port_out_0_o}, 3'h7);
		shutdown_n_i = 1'b1;
		wait_idle;
		check(conversion_strobe_o, 1'b1);
		reset_low_input_n_i = 1'b0;
		tick(6);
		check({polarity_sel_o, port_out_2_o, port_out_1_o, port_out_0_o, busy_o}, 5'h00);
		reset_low_input_n_i = 1'b1;
		tick(4);
		summarize;
	end
endmodule
`default_nettype wire

// ---- verif/asp_host_model.sv ----
// Serial master model that frames control bytes and gathers result bits.
`timescale 1ns/100ps
`default_nettype none
module asp_host_model (
	input  wire logic core_clk_i,
	input  wire logic res_i,
	input  wire logic res_oe_n_i,
	output var  logic cs_n_o = 1'b1,
	output var  logic sclk_o = 1'b0,
	output var  logic ctl_o = 1'b0
);
	logic last = 1'b0;
	// A released result line is seen as the inverse of its last driven value.
	always @(posedge core_clk_i) begin
		if (!res_oe_n_i) last <= res_i;
	end
	task automatic half;
		repeat (4) @(posedge core_clk_i);
		#1;
	endtask
	// Frame of two idle zeros, the control byte, then zeros while the result shifts out.
	task automatic xfer(input logic [7:0] cb, input int n, output logic [31:0] rx);
		rx = 32'h0;
		half;
		cs_n_o = 1'b0;
		half;
		half;
		for (int i = 0; i < n; i++) begin
			ctl_o = (i > 1 && i < 10) ? cb[9-i] : 1'b0;
			half;
			sclk_o = 1'b1;
			half;
			rx = {rx[30:0], res_oe_n_i ? ~last : res_i};
			sclk_o = 1'b0;
		end
		half;
		cs_n_o = 1'b1;
	endtask
endmodule
`default_nettype wire
